// ===== hw/adccc_tad_gen.v
// Purpose: Produce one enable pulse per converter clock period.
// Assumes: Single clock pclk, asynchronous active-low reset.
// Notes: The RC path is modelled as a fixed divider started after one instruction cycle.
`timescale 1ns/1ps
`default_nettype none
`include "adccc_defs.vh"

module adccc_tad_gen
(
	input wire pclk,
	input wire presetn,
	input wire run,
	input wire [2:0] clk_sel,
	output reg tad_pulse
);

	reg [6:0] div_q;
	reg [7:0] rc_wait_q;
	reg [6:0] limit;
	wire use_rc;
	wire hold;

	// The RC divider limit is formed at full width and trimmed on purpose.
	localparam [7:0] RC_LIMIT = `ADCCC_RC_DIV - 8'd1;

	assign use_rc = (clk_sel[1:0] == 2'b11);

	always @*
	begin
		case (clk_sel)
			3'b000: limit = 7'd1;
			3'b100: limit = 7'd3;
			3'b001: limit = 7'd7;
			3'b101: limit = 7'd15;
			3'b010: limit = 7'd31;
			3'b110: limit = 7'd63;
			default: limit = RC_LIMIT[6:0];
		endcase
	end

	// RC clock waits one instruction cycle before its first period begins.
	assign hold = use_rc && (rc_wait_q != 8'd0);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q <= 7'd0;
			rc_wait_q <= 8'd0;
			tad_pulse <= 1'b0;
		end
		else if (!run)
		begin
			div_q <= 7'd0;
			rc_wait_q <= `ADCCC_INSTR_CYCLE_CLKS;
			tad_pulse <= 1'b0;
		end
		else if (hold)
		begin
			rc_wait_q <= rc_wait_q - 8'd1;
			tad_pulse <= 1'b0;
		end
		else if (div_q >= limit)
		begin
			div_q <= 7'd0;
			tad_pulse <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 7'd1;
			tad_pulse <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== hw/adccc_top.v
// Purpose: Configuration, timing and sequencing of a 12-bit converter, reached over APB.
// Assumes: Analog front end returns a 12-bit sample on sample_data when asked.
// Notes: Reference and pin routing leave as registered control outputs.
// Operation
// - Bit 5 picks negative reference pin or ground.
// - Bit 4 picks positive reference pin or supply.
// - Pin field sets analog/digital map from top.
// - Fuse chooses pin field reset 0000 or 0111.
// - Inputs 5-7 exist only on large variants.
// - Acquisition field picks 0 to 20 periods.
// - Upper clock codes: RC, /64, /16, /4.
// - Start waits programmed acquisition before converting.
// - Done loads result, clears start, flags.
// - RC clock starts after one instruction cycle.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adccc_defs.vh"

module adccc_top
#(
	parameter LARGE_VARIANT = 1
)
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire portb_analog_default_fuse,
	input wire [11:0] sample_data,
	output reg neg_reference_select,
	output reg pos_reference_select,
	output reg [12:0] analog_pin_en,
	output reg sample_hold,
	output reg irq
);

	localparam ST_IDLE = 2'd0;
	localparam ST_ACQ = 2'd1;
	localparam ST_CONV = 2'd2;
	localparam ST_SETTLE = 2'd3;

	reg [7:0] refpin_q;
	reg [7:0] fmtacq_q;
	reg enable_q;
	reg start_q;
	reg [15:0] result_q;
	reg done_flag_q;
	reg mask_q;
	reg [1:0] state_q;
	reg [4:0] cnt_q;
	reg fuse_loaded_q;
	reg [4:0] acq_tads;
	wire [12:0] pin_map;
	reg [31:0] rdata;
	reg addr_ok;
	wire tad_pulse;
	wire wr_en;
	wire rd_en;
	wire done_evt;
	wire [3:0] pin_analog_config;

	assign pin_analog_config = refpin_q[3:0];
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;
	assign done_evt = (state_q == ST_CONV) && tad_pulse && (cnt_q == 5'd0);

	always @*
	begin
		case (fmtacq_q[`ADCCC_ACQ_LSB +: 3])
			3'b111: acq_tads = 5'd20;
			3'b110: acq_tads = 5'd16;
			3'b101: acq_tads = 5'd12;
			3'b100: acq_tads = 5'd8;
			3'b011: acq_tads = 5'd6;
			3'b010: acq_tads = 5'd4;
			3'b001: acq_tads = 5'd2;
			default: acq_tads = 5'd0;
		endcase
	end

	// Codes 0000-0010 are all analog; each higher code turns one more pin digital.
	genvar gi;
	generate
		for (gi = 0; gi < `ADCCC_NUM_INPUTS; gi = gi + 1)
		begin : g_pin
			// Input n stays analog while the code is below 15 - n.
			localparam integer FIRST_DIGITAL_CODE = 15 - gi;
			if (!LARGE_VARIANT && gi >= 5 && gi <= 7)
			begin : g_absent
				assign pin_map[gi] = 1'b0;
			end
			else
			begin : g_present
				assign pin_map[gi] = {28'h000_0000, pin_analog_config} < FIRST_DIGITAL_CODE;
			end
		end
	endgenerate

	adccc_tad_gen u_tad
	(
		.pclk(pclk),
		.presetn(presetn),
		.run(state_q != ST_IDLE),
		.clk_sel(fmtacq_q[`ADCCC_CLK_LSB +: 3]),
		.tad_pulse(tad_pulse)
	);

	always @*
	begin
		addr_ok = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			`ADCCC_OFF_REFPIN: rdata = {24'h00_0000, refpin_q & `ADCCC_REFPIN_WMASK};
			`ADCCC_OFF_FMTACQ: rdata = {24'h00_0000, fmtacq_q & `ADCCC_FMTACQ_WMASK};
			`ADCCC_OFF_CTRL: rdata = {30'h0000_0000, start_q, enable_q};
			`ADCCC_OFF_RESULT: rdata = {16'h0000, result_q};
			`ADCCC_OFF_STATUS: rdata = {31'h0000_0000, done_flag_q};
			`ADCCC_OFF_MASK: rdata = {31'h0000_0000, mask_q};
			default: addr_ok = 1'b0;
		endcase
	end

	// Bus answers with a one-cycle access phase; read data are latched in setup.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (rd_en)
				prdata <= rdata;
			else if (psel && !penable)
				prdata <= 32'h0000_0000;
		end
	end

	// The fuse is sampled by a clocked load after reset release, never inside the reset.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			refpin_q <= 8'h00;
			fuse_loaded_q <= 1'b0;
			fmtacq_q <= `ADCCC_FMTACQ_RESET;
			mask_q <= 1'b0;
		end
		else
		begin
			if (!fuse_loaded_q)
			begin
				fuse_loaded_q <= 1'b1;
				refpin_q[3:0] <= portb_analog_default_fuse ? `ADCCC_PCFG_FUSE1
					: `ADCCC_PCFG_FUSE0;
			end
			else if (wr_en && paddr == `ADCCC_OFF_REFPIN)
				refpin_q <= pwdata[7:0] & `ADCCC_REFPIN_WMASK;
			if (wr_en && paddr == `ADCCC_OFF_FMTACQ)
				fmtacq_q <= pwdata[7:0] & `ADCCC_FMTACQ_WMASK;
			if (wr_en && paddr == `ADCCC_OFF_MASK)
				mask_q <= pwdata[0];
		end
	end

	// Conversion sequencer: acquisition, thirteen bit periods, then two settle periods.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 5'd0;
			enable_q <= 1'b0;
			start_q <= 1'b0;
			result_q <= 16'h0000;
			sample_hold <= 1'b0;
		end
		else
		begin
			if (wr_en && paddr == `ADCCC_OFF_CTRL)
			begin
				enable_q <= pwdata[`ADCCC_CTRL_ENABLE];
				if (pwdata[`ADCCC_CTRL_START] && pwdata[`ADCCC_CTRL_ENABLE] && state_q == ST_IDLE)
				begin
					start_q <= 1'b1;
					state_q <= ST_ACQ;
					cnt_q <= acq_tads;
				end
			end
			case (state_q)
				ST_ACQ:
				begin
					// Leaving on the last period's pulse keeps the wait exactly N periods.
					if (cnt_q == 5'd0 || (tad_pulse && cnt_q == 5'd1))
					begin
						state_q <= ST_CONV;
						cnt_q <= `ADCCC_CONV_TADS - 5'd1;
						sample_hold <= 1'b1;
					end
					else if (tad_pulse)
						cnt_q <= cnt_q - 5'd1;
				end
				ST_CONV:
				begin
					if (done_evt)
					begin
						result_q <= fmtacq_q[`ADCCC_BIT_JUSTIFY] ? {4'h0, sample_data}
							: {sample_data, 4'h0};
						start_q <= 1'b0;
						sample_hold <= 1'b0;
						state_q <= ST_SETTLE;
						cnt_q <= `ADCCC_SETTLE_TADS;
					end
					else if (tad_pulse)
						cnt_q <= cnt_q - 5'd1;
				end
				ST_SETTLE:
				begin
					if (cnt_q == 5'd0)
						state_q <= ST_IDLE;
					else if (tad_pulse)
						cnt_q <= cnt_q - 5'd1;
				end
				default:
				begin
					sample_hold <= 1'b0;
				end
			endcase
			if (!enable_q && state_q != ST_IDLE && !(wr_en && paddr == `ADCCC_OFF_CTRL))
			begin
				state_q <= ST_IDLE;
				start_q <= 1'b0;
				sample_hold <= 1'b0;
			end
		end
	end

	// Set wins over a same-cycle write-one-to-clear.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_flag_q <= 1'b0;
			irq <= 1'b0;
			neg_reference_select <= 1'b0;
			pos_reference_select <= 1'b0;
			analog_pin_en <= 13'h0000;
		end
		else
		begin
			if (done_evt)
				done_flag_q <= 1'b1;
			else if (wr_en && paddr == `ADCCC_OFF_STATUS && pwdata[0])
				done_flag_q <= 1'b0;
			irq <= (done_flag_q || done_evt) && mask_q;
			neg_reference_select <= refpin_q[`ADCCC_BIT_NEGREF];
			pos_reference_select <= refpin_q[`ADCCC_BIT_POSREF];
			analog_pin_en <= pin_map;
		end
	end

endmodule
`default_nettype wire

// ===== include/adccc_defs.vh
// Purpose: Constants for the converter configuration and timing control block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Register offsets here are local choices.
`ifndef ADCCC_DEFS_VH
`define ADCCC_DEFS_VH

`define ADCCC_OFF_REFPIN 12'h000
`define ADCCC_OFF_FMTACQ 12'h004
`define ADCCC_OFF_CTRL 12'h008
`define ADCCC_OFF_RESULT 12'h00C
`define ADCCC_OFF_STATUS 12'h010
`define ADCCC_OFF_MASK 12'h014

`define ADCCC_REFPIN_WMASK 8'h3F
`define ADCCC_FMTACQ_WMASK 8'hBF
`define ADCCC_FMTACQ_RESET 8'h00
`define ADCCC_PCFG_FUSE1 4'h0
`define ADCCC_PCFG_FUSE0 4'h7

`define ADCCC_BIT_NEGREF 5
`define ADCCC_BIT_POSREF 4
`define ADCCC_BIT_JUSTIFY 7
`define ADCCC_ACQ_LSB 3
`define ADCCC_CLK_LSB 0

`define ADCCC_CTRL_ENABLE 0
`define ADCCC_CTRL_START 1

`define ADCCC_NUM_INPUTS 13
`define ADCCC_CONV_TADS 5'd13
`define ADCCC_SETTLE_TADS 5'd2
`define ADCCC_INSTR_CYCLE_CLKS 8'd4
`define ADCCC_RC_DIV 8'd8

`endif

// ===== verification/adccc_asserts.sv
// Purpose: Port checks for the converter configuration block.
// Assumes: One clock, reset active low.
// Notes: The pin map is worked out here, not taken from the design.
`timescale 1ns/1ps
`default_nettype none
module adccc_asserts
#(
	parameter LARGE_VARIANT = 1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic portb_analog_default_fuse,
	input wire logic neg_reference_select,
	input wire logic pos_reference_select,
	input wire logic [12:0] analog_pin_en,
	input wire logic irq
);
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
wire logic acc = psel && penable && pready;
function automatic logic [12:0] pin_map(input logic [3:0] c);
	logic [12:0] m;
	m = 13'h1FFF >> ((c < 4'h3) ? 4'h0 : c - 4'h2);
	pin_map = LARGE_VARIANT ? m : m & 13'h1F1F;
endfunction
a_ready_after_setup: assert property (psel && !penable |=> pready)
	else $error("no answer after setup");
a_ready_one_cycle: assert property (pready |=> !pready)
	else $error("ready held too long");
a_error_with_ready: assert property (pslverr |-> pready)
	else $error("error without ready");
a_unmapped_error: assert property (psel && !penable && paddr > 12'h014 |=> pslverr && prdata == 0)
	else $error("unmapped access not refused");
a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 0)
	else $error("upper read bits set");
a_negref_follows: assert property (acc && pwrite && paddr == 12'h000
	|-> ##2 neg_reference_select == $past(pwdata[5], 2))
	else $error("negative reference wrong");
a_posref_follows: assert property (acc && pwrite && paddr == 12'h000
	|-> ##2 pos_reference_select == $past(pwdata[4], 2))
	else $error("positive reference wrong");
a_pin_map_write: assert property (acc && pwrite && paddr == 12'h000
	|-> ##2 analog_pin_en == pin_map($past(pwdata[3:0], 2))) else $error("pin map wrong");
a_fuse_reset: assert property ($rose(presetn) |-> ##2
	analog_pin_en == pin_map(portb_analog_default_fuse ? 4'h0 : 4'h7))
	else $error("pin map after reset wrong");
c_ctrl_write: cover property (acc && pwrite && paddr == 12'h008);
c_irq_rise: cover property ($rose(irq));
c_refused: cover property (pslverr);
endmodule
bind adccc_top adccc_asserts #(.LARGE_VARIANT(LARGE_VARIANT)) i_chk
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.portb_analog_default_fuse(portb_analog_default_fuse), .irq(irq),
	.neg_reference_select(neg_reference_select),
	.pos_reference_select(pos_reference_select), .analog_pin_en(analog_pin_en)
);
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the converter configuration block.
// Assumes: Answers arrive within 20 cycles, conversions within 2000.
// Notes: Delays are compared as differences, so divider phase cancels out.
`timescale 1ns/1ps
`default_nettype none
`include "adccc_defs.vh"
module tb_top;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fuse = 0;
logic [11:0] paddr = 0, sdata = 12'hABC;
logic [31:0] pwdata = 0, rd, prdata;
logic pready, pslverr, neg, pos, hold, irq, err;
logic [12:0] pin_en;
int fail_count = 0, n_tests = 0, a0, ak, h, k;
int acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
int div_t[8] = '{2, 8, 32, 8, 4, 16, 64, 8};
adccc_top i_dut
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.portb_analog_default_fuse(fuse), .sample_data(sdata), .neg_reference_select(neg),
	.pos_reference_select(pos), .analog_pin_en(pin_en), .sample_hold(hold), .irq(irq)
);
initial
begin
	forever #4 pclk = ~pclk;
end
task close_out;
	$display("Compared %0d, mismatched %0d", n_tests, fail_count);
	if (fail_count == 0 && n_tests > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
task timeout;
	fail_count++;
	$display("MISMATCH %0t wait limit used up", $time);
	close_out();
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
	n_tests++;
	if (got !== exp)
	begin
		fail_count++;
		$display("MISMATCH %0t got %h expected %h", $time, got, exp);
	end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	int i;
	@(posedge pclk);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	for (i = 0; i < 20; i++)
	begin
		@(posedge pclk);
		if (pready === 1'b1)
			break;
	end
	if (i == 20)
		timeout();
	rd = prdata;
	err = pslverr;
	psel <= 0;
	penable <= 0;
	@(posedge pclk);
endtask
task wait_hold(input logic lvl, output int n);
	for (n = 0; hold !== lvl; n++)
	begin
		if (n == 2000)
			timeout();
		@(posedge pclk);
	end
endtask
// The trailing idle lets the two settle periods pass before the next start.
task conv(input logic [7:0] f);
	apb(1, 12'h004, {24'h0, f});
	apb(1, 12'h008, 32'h0000_0003);
	wait_hold(1, ak);
	wait_hold(0, h);
	apb(0, 12'h008, 0);
	chk(rd[1], 0);
	repeat (150) @(posedge pclk);
endtask
task t_reset;
	for (k = 0; k < 2; k++)
	begin
		presetn <= 0;
		fuse <= k[0];
		repeat (5) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		chk(pin_en, k ? 13'h1FFF : 13'h00FF);
		apb(0, 12'h000, 0);
		chk(rd, k ? 0 : 32'h0000_0007);
		apb(0, 12'h004, 0);
		chk(rd, 0);
	end
endtask
task t_regs;
	for (k = 0; k < 4; k++)
	begin
		apb(1, 12'h000, 32'h0000_00CF | (k << 4));
		@(posedge pclk);
		chk({neg, pos}, k);
		apb(0, 12'h000, 0);
		chk(rd, 32'h0000_000F | (k << 4));
	end
	for (k = 0; k < 16; k++)
	begin
		apb(1, 12'h000, k);
		@(posedge pclk);
		chk(pin_en, 13'h1FFF >> (k < 3 ? 0 : k - 2));
	end
	apb(1, 12'h004, 32'hFFFF_FFFF);
	apb(0, 12'h004, 0);
	chk(rd, 32'h0000_00BF);
	apb(0, 12'h018, 0);
	chk(err, 1);
	chk(rd, 0);
endtask
task t_conv;
	conv(8'h00);
	a0 = ak;
	for (k = 1; k < 8; k++)
	begin
		conv(8'(k << 3));
		chk(ak - a0, 2 * acq_t[k]);
	end
	for (k = 0; k < 8; k++)
	begin
		conv(8'(k));
		chk(h, 13 * div_t[k] + (k[1:0] == 2'b11 ? `ADCCC_INSTR_CYCLE_CLKS : 8'd0));
	end
endtask
task t_irq;
	conv(8'h80);
	chk(irq, 0);
	apb(0, 12'h00C, 0);
	chk(rd, 32'h0000_0ABC);
	apb(0, 12'h010, 0);
	chk(rd, 1);
	apb(1, 12'h014, 1);
	@(posedge pclk);
	chk(irq, 1);
	apb(1, 12'h010, 1);
	@(posedge pclk);
	chk(irq, 0);
	conv(8'h00);
	apb(0, 12'h00C, 0);
	chk(rd, 32'h0000_ABC0);
	chk(irq, 1);
endtask
initial
begin
	t_reset();
	t_regs();
	t_conv();
	t_irq();
	close_out();
end
endmodule
`default_nettype wire
